/* design/pck_engine.sv */
// Payload cipher framing (chaining/counter) and session key derivation engine
//
// What this block does
// - Chaining or counter mode chosen per context.
// - 128-bit chaining uses fresh 16-byte random IV.
// - IV sent clear, ahead of the ciphertext.
// - 64-bit legacy chaining uses all-zero IV.
// - Counter block: nonce, master counter, block counter.
// - Nonce arrives with key, constant per key.
// - Master counter cleared on new session key.
// - Master counter increments once per unit.
// - Master counter sent clear ahead of ciphertext.
// - Block counter starts one, steps per keystream block.
// - No counter block reuse under one key.
// - Refuse counter units above the length limit.
// - Padding bytes count upward from one.
// - Aligned plaintext still gets a full pad block.
// - Pad to 16 or 8 octets by cipher.
// - Counter mode adds no padding.
// - Auth is keyed hash of cookie over nonces.
// - Full exchange temp from shared secret hash.
// - New cookie from temp with tag one.
// - Key sections from temp with tag two.
// - Quick exchange temp keyed by cookie, tag three.
// - Full exchange message order controller then terminal.
// - Keyed hash is HMAC-SHA1, 20-byte digest.
// - Integers serialised big-endian, zero-padded high.
`include "pck_defs.svh"

module pck_engine (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Security context
    input wire logic i_ctx_ctr,
    input wire logic i_ctx_aes,
    input wire logic i_new_key,
    input wire logic [31:0] i_key_nonce,
    // Unit framing
    input wire logic i_unit_start,
    input wire logic [35:0] i_unit_len,
    input wire logic [127:0] i_rand_iv,
    output logic o_unit_accept,
    output logic o_unit_reject,
    output logic [127:0] o_prefix,
    output logic [4:0] o_prefix_len,
    output logic [4:0] o_pad_len,
    // Keystream counter
    input wire logic i_ks_next,
    output logic [127:0] o_ctr_block,
    // Padding byte stream
    input wire logic i_pad_ready,
    output logic o_pad_valid,
    output logic [7:0] o_pad_byte,
    // Receive-side pad strip
    input wire logic i_strip_req,
    input wire logic [7:0] i_last_byte,
    output logic [7:0] o_strip_len,
    output logic o_strip_bad,
    // Key exchange control
    input wire logic i_kx_start,
    input wire logic [1:0] i_kx_kind,
    input wire logic i_kx_new_cookie,
    input wire logic [127:0] i_enc_key,
    output logic o_kx_done,
    output logic [159:0] o_auth,
    output logic [159:0] o_new_cookie,
    output logic o_cookie_valid,
    output logic [127:0] o_session_key,
    // Keyed-hash core
    input wire logic i_hash_done,
    input wire logic [159:0] i_hash_digest,
    output logic o_hash_req,
    output logic [2:0] o_hash_op,
    output logic [7:0] o_hash_tag,
    output logic [7:0] o_hash_idx,
    output logic [159:0] o_hash_temp
);

    // ======================================================
    // Framing state
    logic [31:0] nonce, next_nonce;
    logic [63:0] master, next_master;
    logic [31:0] blk, next_blk;
    logic key_spent, next_key_spent;
    logic next_unit_accept, next_unit_reject;
    logic [127:0] next_prefix, next_ctr_block;
    logic [4:0] next_prefix_len, next_pad_len;
    logic next_pad_valid;
    logic [7:0] next_pad_byte;
    logic [7:0] next_strip_len;
    logic next_strip_bad;
    logic unit_ok;

    // Refuse while pad bytes still drain, so units never interleave
    assign unit_ok = !o_pad_valid
        && !(i_ctx_ctr && (key_spent || i_unit_len > `PCK_CTR_MAX_LEN));

    always_comb begin
        next_nonce = nonce;
        next_master = master;
        next_blk = blk;
        next_key_spent = key_spent;
        next_unit_accept = 1'b0;
        next_unit_reject = 1'b0;
        next_prefix = o_prefix;
        next_prefix_len = o_prefix_len;
        next_pad_len = o_pad_len;
        next_pad_valid = o_pad_valid;
        next_pad_byte = o_pad_byte;
        next_strip_len = o_strip_len;
        next_strip_bad = o_strip_bad;
        if (i_new_key) begin
            next_nonce = i_key_nonce;
            next_master = `PCK_MASTER_RESET;
            next_key_spent = 1'b0;
        end else if (i_unit_start && unit_ok) begin
            next_unit_accept = 1'b1;
            if (i_ctx_ctr) begin
                next_prefix = {master, 64'h0};
                next_prefix_len = `PCK_CTR_HDR_LEN;
                next_pad_len = 5'h00;
                next_blk = `PCK_BLK_FIRST;
                next_master = master + `PCK_MASTER_STEP;
                next_key_spent = (master == `PCK_MASTER_LAST);
            end else begin
                next_pad_valid = 1'b1;
                next_pad_byte = `PCK_PAD_FIRST;
                if (i_ctx_aes) begin
                    next_prefix = i_rand_iv;
                    next_prefix_len = `PCK_AES_IV_LEN;
                    next_pad_len = `PCK_AES_BLOCK - {1'b0, i_unit_len[3:0]};
                end else begin
                    next_prefix = 128'h0;
                    next_prefix_len = `PCK_DES_IV_LEN;
                    next_pad_len = `PCK_DES_BLOCK - {2'b0, i_unit_len[2:0]};
                end
            end
        end else if (i_unit_start) begin
            next_unit_reject = 1'b1;
        end
        if (i_ks_next && !(i_unit_start && unit_ok)) begin
            next_blk = blk + `PCK_BLK_STEP;
        end
        if (o_pad_valid && i_pad_ready) begin
            if (o_pad_byte == {3'b0, o_pad_len}) begin
                next_pad_valid = 1'b0;
            end else begin
                next_pad_byte = o_pad_byte + `PCK_PAD_STEP;
            end
        end
        if (i_strip_req) begin
            // Pad length can never exceed one block of the active cipher
            next_strip_len = i_last_byte;
            next_strip_bad = (i_last_byte == 8'h00)
                || (i_last_byte > {3'b0, i_ctx_aes ? `PCK_AES_BLOCK : `PCK_DES_BLOCK});
        end
        // Keystream must use the master value sent in the header, not the stepped one
        next_ctr_block = {next_nonce, next_prefix[127:64], next_blk};
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            nonce <= 32'h0;
            master <= `PCK_MASTER_RESET;
            blk <= `PCK_BLK_FIRST;
            key_spent <= 1'b0;
            o_unit_accept <= 1'b0;
            o_unit_reject <= 1'b0;
            o_prefix <= 128'h0;
            o_prefix_len <= 5'h00;
            o_pad_len <= 5'h00;
            o_pad_valid <= 1'b0;
            o_pad_byte <= 8'h00;
            o_strip_len <= 8'h00;
            o_strip_bad <= 1'b0;
            o_ctr_block <= 128'h0;
        end else begin
            nonce <= next_nonce;
            master <= next_master;
            blk <= next_blk;
            key_spent <= next_key_spent;
            o_unit_accept <= next_unit_accept;
            o_unit_reject <= next_unit_reject;
            o_prefix <= next_prefix;
            o_prefix_len <= next_prefix_len;
            o_pad_len <= next_pad_len;
            o_pad_valid <= next_pad_valid;
            o_pad_byte <= next_pad_byte;
            o_strip_len <= next_strip_len;
            o_strip_bad <= next_strip_bad;
            o_ctr_block <= next_ctr_block;
        end
    end

    // ======================================================
    // Key exchange sequencer
    pck_pkg::pck_kx_state_t state, next_state;
    pck_pkg::pck_kx_kind_t kind, next_kind;
    logic upd, next_upd;
    logic next_hash_req, next_kx_done, next_cookie_valid;
    logic [2:0] next_hash_op;
    logic [7:0] next_hash_tag, next_hash_idx;
    logic [159:0] next_hash_temp, next_auth, next_new_cookie;
    logic [127:0] next_session_key, key_raw;

    // Leading bytes of section one; legacy key keeps eight bytes high
    assign key_raw = (i_hash_digest[159:32] ^ (kind == pck_pkg::KX_DELIVERED ? i_enc_key : 128'h0))
        & (i_ctx_aes ? {128{1'b1}} : {{64{1'b1}}, 64'h0});

    always_comb begin
        next_state = state;
        next_kind = kind;
        next_upd = upd;
        next_hash_req = o_hash_req;
        next_hash_op = o_hash_op;
        next_hash_tag = o_hash_tag;
        next_hash_idx = o_hash_idx;
        next_hash_temp = o_hash_temp;
        next_auth = o_auth;
        next_new_cookie = o_new_cookie;
        next_session_key = o_session_key;
        next_kx_done = 1'b0;
        next_cookie_valid = 1'b0;
        unique case (state)
            pck_pkg::ST_IDLE: begin
                if (i_kx_start) begin
                    next_kind = pck_pkg::pck_kx_kind_t'(i_kx_kind);
                    next_upd = i_kx_new_cookie && (i_kx_kind == pck_pkg::KX_FULL);
                    next_state = pck_pkg::ST_AUTH;
                    next_hash_req = 1'b1;
                    next_hash_op = pck_pkg::OP_AUTH;
                    next_hash_tag = `PCK_TAG_NONE;
                    next_hash_idx = `PCK_SECTION_NONE;
                end
            end
            pck_pkg::ST_AUTH: begin
                if (i_hash_done) begin
                    next_auth = i_hash_digest;
                    next_state = pck_pkg::ST_TEMP;
                    unique case (kind)
                        pck_pkg::KX_FULL: begin
                            next_hash_op = pck_pkg::OP_TEMP_FULL;
                        end
                        pck_pkg::KX_COOKIE: begin
                            next_hash_op = pck_pkg::OP_TEMP_COOKIE;
                            next_hash_tag = `PCK_TAG_QUICK;
                        end
                        default: begin
                            next_hash_op = pck_pkg::OP_TEMP_DELIV;
                            next_hash_tag = `PCK_TAG_DELIV;
                        end
                    endcase
                end
            end
            pck_pkg::ST_TEMP: begin
                if (i_hash_done) begin
                    next_hash_temp = i_hash_digest;
                    next_hash_op = pck_pkg::OP_SECTION;
                    next_hash_idx = `PCK_SECTION_ONE;
                    next_state = upd ? pck_pkg::ST_COOKIE : pck_pkg::ST_KEY;
                    next_hash_tag = upd ? `PCK_TAG_COOKIE : `PCK_TAG_KEY;
                end
            end
            pck_pkg::ST_COOKIE: begin
                if (i_hash_done) begin
                    // One 20-byte section covers the whole cookie
                    next_new_cookie = i_hash_digest;
                    next_cookie_valid = 1'b1;
                    next_hash_tag = `PCK_TAG_KEY;
                    next_state = pck_pkg::ST_KEY;
                end
            end
            pck_pkg::ST_KEY: begin
                if (i_hash_done) begin
                    next_session_key = key_raw;
                    next_kx_done = 1'b1;
                    next_hash_req = 1'b0;
                    next_hash_op = pck_pkg::OP_NONE;
                    next_hash_tag = `PCK_TAG_NONE;
                    next_hash_idx = `PCK_SECTION_NONE;
                    next_state = pck_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = pck_pkg::ST_IDLE;
                next_hash_req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= pck_pkg::ST_IDLE;
            kind <= pck_pkg::KX_FULL;
            upd <= 1'b0;
            o_hash_req <= 1'b0;
            o_hash_op <= pck_pkg::OP_NONE;
            o_hash_tag <= `PCK_TAG_NONE;
            o_hash_idx <= `PCK_SECTION_NONE;
            o_hash_temp <= 160'h0;
            o_auth <= 160'h0;
            o_new_cookie <= 160'h0;
            o_session_key <= 128'h0;
            o_kx_done <= 1'b0;
            o_cookie_valid <= 1'b0;
        end else begin
            state <= next_state;
            kind <= next_kind;
            upd <= next_upd;
            o_hash_req <= next_hash_req;
            o_hash_op <= next_hash_op;
            o_hash_tag <= next_hash_tag;
            o_hash_idx <= next_hash_idx;
            o_hash_temp <= next_hash_temp;
            o_auth <= next_auth;
            o_new_cookie <= next_new_cookie;
            o_session_key <= next_session_key;
            o_kx_done <= next_kx_done;
            o_cookie_valid <= next_cookie_valid;
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    a_new_key_clear: assert property (i_new_key |=> master == `PCK_MASTER_RESET)
        else $error("master counter not cleared by new key");
    a_master_step: assert property (i_unit_start && unit_ok && i_ctx_ctr && !i_new_key
        |=> master == $past(master) + `PCK_MASTER_STEP && o_prefix[127:64] == $past(master))
        else $error("master counter step or header wrong");
    a_blk_first: assert property (o_unit_accept && i_ctx_ctr |-> o_ctr_block[31:0] == `PCK_BLK_FIRST
        && o_ctr_block[95:32] == o_prefix[127:64])
        else $error("block counter not one at unit start");
    a_ctr_nonce: assert property (##1 !$past(i_new_key) |-> o_ctr_block[127:96] == $past(nonce))
        else $error("nonce field changed without new key");
    a_ctr_len_cap: assert property (i_unit_start && i_ctx_ctr && i_unit_len > `PCK_CTR_MAX_LEN
        && !i_new_key |=> o_unit_reject && !o_unit_accept)
        else $error("oversized counter unit accepted");
    a_legacy_iv: assert property (o_unit_accept && $past(!i_ctx_ctr && !i_ctx_aes)
        |-> o_prefix == 128'h0 && o_prefix_len == `PCK_DES_IV_LEN)
        else $error("legacy IV not zero");
    a_pad_full: assert property (i_unit_start && unit_ok && !i_new_key && !i_ctx_ctr && i_ctx_aes
        && i_unit_len[3:0] == 4'h0 |=> o_pad_len == `PCK_AES_BLOCK)
        else $error("aligned unit missing full pad block");
    a_pad_count: assert property (o_pad_valid && i_pad_ready && o_pad_byte != {3'b0, o_pad_len}
        |=> o_pad_byte == $past(o_pad_byte) + `PCK_PAD_STEP)
        else $error("pad byte not counting upward");
    a_ctr_no_pad: assert property (o_unit_accept && $past(i_ctx_ctr) |-> o_pad_len == 5'h00 && !o_pad_valid)
        else $error("counter unit padded");
    a_kx_order: assert property (state == pck_pkg::ST_AUTH |-> o_hash_req && o_hash_op == pck_pkg::OP_AUTH)
        else $error("auth not first hash request");
    a_quick_tag: assert property (state == pck_pkg::ST_TEMP && kind == pck_pkg::KX_COOKIE
        |-> o_hash_tag == `PCK_TAG_QUICK)
        else $error("quick exchange tag wrong");

    c_ctr_unit: cover property (o_unit_accept && o_pad_len == 5'h00);
    c_cbc_pad_done: cover property (o_pad_valid ##1 !o_pad_valid);
    c_full_cookie: cover property (o_cookie_valid ##[1:1000] o_kx_done);
    c_reject: cover property (o_unit_reject);

endmodule // pck_engine

/* inc/pck_defs.svh */
// Constants for the payload cipher framing and keying engine
`ifndef PCK_DEFS_SVH
`define PCK_DEFS_SVH

// ==========================================================
// Cipher block sizes and header lengths, in octets
`define PCK_AES_BLOCK 5'h10
`define PCK_DES_BLOCK 5'h08
`define PCK_AES_IV_LEN 5'h10
`define PCK_DES_IV_LEN 5'h08
`define PCK_CTR_HDR_LEN 5'h08

// ==========================================================
// Counter block fields
`define PCK_MASTER_RESET 64'h0000_0000_0000_0000
`define PCK_MASTER_LAST 64'hFFFF_FFFF_FFFF_FFFF
`define PCK_MASTER_STEP 64'h0000_0000_0000_0001
`define PCK_BLK_FIRST 32'h0000_0001
`define PCK_BLK_STEP 32'h0000_0001
`define PCK_CTR_MAX_LEN 36'hF_FFFF_FFF0

// ==========================================================
// Padding byte sequence
`define PCK_PAD_FIRST 8'h01
`define PCK_PAD_STEP 8'h01

// ==========================================================
// Keyed-hash suffix tags and section index
`define PCK_TAG_COOKIE 8'h01
`define PCK_TAG_KEY 8'h02
`define PCK_TAG_QUICK 8'h03
`define PCK_TAG_DELIV 8'h04
`define PCK_TAG_NONE 8'h00
`define PCK_SECTION_ONE 8'h01
`define PCK_SECTION_NONE 8'h00

`endif

/* inc/pck_pkg.sv */
// Types shared by the payload cipher framing and keying engine
package pck_pkg;

    // ======================================================
    // Key exchange kinds
    typedef enum logic [1:0] {
        KX_FULL = 2'h0,
        KX_COOKIE = 2'h1,
        KX_DELIVERED = 2'h2
    } pck_kx_kind_t;

    // ======================================================
    // Requests to the external keyed-hash core
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_AUTH = 3'h1,
        OP_TEMP_FULL = 3'h2,
        OP_TEMP_COOKIE = 3'h3,
        OP_TEMP_DELIV = 3'h4,
        OP_SECTION = 3'h5
    } pck_hash_op_t;

    // ======================================================
    // Key exchange sequencer
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_AUTH = 3'h1,
        ST_TEMP = 3'h2,
        ST_COOKIE = 3'h3,
        ST_KEY = 3'h4
    } pck_kx_state_t;

endpackage

/* verification/pck_hash_model.sv */
// Behavioural keyed-hash core that answers the engine's hash requests
module pck_hash_model #(
    parameter logic [135:0] SALT = 136'h5A3C_96E1_0F87_2D4B_C3A5_1E69_F0B8_7D24_99
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Request from the engine
    input wire logic i_req,
    input wire logic [2:0] i_op,
    input wire logic [7:0] i_tag,
    input wire logic [7:0] i_idx,
    input wire logic [3:0] i_delay,
    // Answer
    output logic o_done,
    output logic [159:0] o_digest
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic next_done;
    logic [159:0] next_digest;

    // ======================================================
    // Answer after i_delay plus two idle cycles
    always_comb begin
        next_cnt = 5'h00;
        next_done = 1'b0;
        next_digest = o_digest;
        if (o_done) begin
            // Released digest must not look like the last answer
            next_digest = ~o_digest;
        end else if (i_req) begin
            if (cnt == {1'b0, i_delay} + 5'h01) begin
                next_done = 1'b1;
                next_digest = {5'h00, i_op, (i_op == 3'h5) ? {i_tag, i_idx} : 16'h0000, SALT};
            end else begin
                next_cnt = cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt <= 5'h00;
            o_done <= 1'b0;
            o_digest <= 160'h0;
        end else begin
            cnt <= next_cnt;
            o_done <= next_done;
            o_digest <= next_digest;
        end
    end
endmodule // pck_hash_model

/* verification/payload_cipher_keying_test.sv */
// Self-checking bench for the payload cipher framing and keying engine
module payload_cipher_keying_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [135:0] SALT = 136'h5A3C_96E1_0F87_2D4B_C3A5_1E69_F0B8_7D24_99;
    typedef struct packed {
        logic rej;
        logic [127:0] pre;
        logic [4:0] plen;
        logic [4:0] pad;
    } pck_unit_t;

    logic i_core_clk, i_reset_n, i_ctx_ctr, i_ctx_aes, i_new_key, i_unit_start;
    logic i_ks_next, i_pad_ready, i_strip_req, i_kx_start, i_kx_new_cookie, i_hash_done;
    logic o_unit_accept, o_unit_reject, o_pad_valid, o_strip_bad, o_kx_done;
    logic o_cookie_valid, o_hash_req;
    logic [31:0] i_key_nonce;
    logic [35:0] i_unit_len;
    logic [127:0] i_rand_iv, i_enc_key, o_prefix, o_ctr_block, o_session_key;
    logic [7:0] i_last_byte, o_pad_byte, o_strip_len, o_hash_tag, o_hash_idx;
    logic [1:0] i_kx_kind;
    logic [159:0] i_hash_digest, o_auth, o_new_cookie, o_hash_temp;
    logic [4:0] o_prefix_len, o_pad_len;
    logic [2:0] o_hash_op, temp_op;
    logic [3:0] dly;
    logic [63:0] master;
    logic [31:0] nonce;
    int seed, fails, checks;
    pck_unit_t unit_q[$];
    pck_unit_t mu;
    logic [7:0] pad_q[$];
    logic [18:0] op_q[$];
    logic [18:0] mh;
    logic [127:0] key_q[$];
    logic ck_q[$];

    pck_engine i_pck_engine (
        .i_core_clk, .i_reset_n, .i_ctx_ctr, .i_ctx_aes, .i_new_key, .i_key_nonce,
        .i_unit_start, .i_unit_len, .i_rand_iv, .o_unit_accept, .o_unit_reject,
        .o_prefix, .o_prefix_len, .o_pad_len, .i_ks_next, .o_ctr_block, .i_pad_ready,
        .o_pad_valid, .o_pad_byte, .i_strip_req, .i_last_byte, .o_strip_len, .o_strip_bad,
        .i_kx_start, .i_kx_kind, .i_kx_new_cookie, .i_enc_key, .o_kx_done, .o_auth,
        .o_new_cookie, .o_cookie_valid, .o_session_key, .i_hash_done, .i_hash_digest,
        .o_hash_req, .o_hash_op, .o_hash_tag, .o_hash_idx, .o_hash_temp
    );

    pck_hash_model #(.SALT(SALT)) i_pck_hash_model (
        .i_clk(i_core_clk), .i_reset_n(i_reset_n), .i_req(o_hash_req), .i_op(o_hash_op),
        .i_tag(o_hash_tag), .i_idx(o_hash_idx), .i_delay(dly), .o_done(i_hash_done),
        .o_digest(i_hash_digest)
    );

    // ======================================================
    // Clock and consumer stalls
    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) #2 i_pad_ready = 1'($random(seed));

    // ======================================================
    // Reporting
    task automatic cmp(input string nm, input logic [159:0] e, input logic [159:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Bounded wait until every noted result has been seen
    task automatic settle();
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge i_core_clk);
            if (unit_q.size() + pad_q.size() + op_q.size() + key_q.size() == 0
                    && o_pad_valid === 1'b0 && o_hash_req === 1'b0) break;
        end
        #2;
        if (n == 400) begin
            fails++;
            give_verdict();
        end
    endtask

    // ======================================================
    // Result watcher
    always @(posedge i_core_clk) begin
        if (i_reset_n === 1'b1) begin
            if (o_unit_accept === 1'b1 || o_unit_reject === 1'b1) begin
                mu = unit_q.pop_front();
                cmp("reject", 160'(mu.rej), 160'(o_unit_reject));
                if (!mu.rej) begin
                    cmp("prefix", 160'(mu.pre), 160'(o_prefix));
                    cmp("prefix len", 160'(mu.plen), 160'(o_prefix_len));
                    cmp("pad len", 160'(mu.pad), 160'(o_pad_len));
                end
            end
            if (o_pad_valid === 1'b1 && i_pad_ready)
                cmp("pad byte", 160'(pad_q.pop_front()), 160'(o_pad_byte));
            if (i_hash_done === 1'b1) begin
                mh = op_q.pop_front();
                cmp("hash op", 160'(mh[18:16]), 160'(o_hash_op));
                if (mh[18:16] >= 3'h3) cmp("hash tag", 160'(mh[15:8]), 160'(o_hash_tag));
                if (mh[18:16] == 3'h5) cmp("hash idx", 160'(mh[7:0]), 160'(o_hash_idx));
            end
            if (o_kx_done === 1'b1) begin
                cmp("session key", 160'(key_q.pop_front()), 160'(o_session_key));
                cmp("auth", {8'h01, 16'h0000, SALT}, o_auth);
                cmp("temp", {5'h00, temp_op, 16'h0000, SALT}, o_hash_temp);
            end
            if (o_cookie_valid === 1'b1)
                cmp("cookie", {8'h05, 8'h01, 8'h01, SALT} ^ 160'(ck_q.pop_front()), o_new_cookie);
        end
    end

    // ======================================================
    // Drivers
    task automatic new_key(input logic [31:0] nv);
        @(posedge i_core_clk);
        #2 i_new_key = 1'b1;
        i_key_nonce = nv;
        @(posedge i_core_clk);
        #2 i_new_key = 1'b0;
        nonce = nv;
        master = 64'h0;
    endtask

    // Holds the start request for n cycles; rej marks the refused ones
    task automatic unit(input logic ctr, aes, input logic [35:0] len, input int n,
                        input logic [2:0] rej);
        pck_unit_t u;
        int p;
        for (int k = 0; k < n; k++) begin
            @(posedge i_core_clk);
            #2 i_ctx_ctr = ctr;
            i_ctx_aes = aes;
            i_unit_len = len;
            i_unit_start = 1'b1;
            i_rand_iv = {$random(seed), $random(seed), $random(seed), $random(seed)};
            p = ctr ? 0 : (aes ? 16 - int'(len[3:0]) : 8 - int'(len[2:0]));
            u.rej = rej[k];
            u.plen = (aes && !ctr) ? 5'h10 : 5'h08;
            u.pad = 5'(p);
            u.pre = ctr ? {master, 64'h0} : (aes ? i_rand_iv : 128'h0);
            if (!rej[k]) begin
                if (ctr) master = master + 64'h1;
                for (int b = 1; b <= p; b++) pad_q.push_back(8'(b));
            end
            unit_q.push_back(u);
        end
        @(posedge i_core_clk);
        #2 i_unit_start = 1'b0;
        settle();
    endtask

    task automatic strip(input logic aes, input logic [7:0] lb, input logic bad);
        @(posedge i_core_clk);
        #2 i_strip_req = 1'b1;
        i_last_byte = lb;
        i_ctx_aes = aes;
        @(posedge i_core_clk);
        #2 i_strip_req = 1'b0;
        cmp("strip bad", 160'(bad), 160'(o_strip_bad));
        if (!bad) cmp("strip len", 160'(lb), 160'(o_strip_len));
    endtask

    task automatic kx(input logic [1:0] kind, input logic nc, aes, input logic [3:0] d);
        logic [127:0] sec;
        sec = {8'h05, 8'h02, 8'h01, SALT[135:32]};
        i_enc_key = {$random(seed), $random(seed), $random(seed), $random(seed)};
        if (kind == 2'h2) sec = sec ^ i_enc_key;
        temp_op = {1'b0, kind} + 3'h2;
        op_q.push_back({3'h1, 16'h0000});
        op_q.push_back(kind == 2'h0 ? {3'h2, 16'h0000} :
                       (kind == 2'h1 ? {3'h3, 16'h0300} : {3'h4, 16'h0400}));
        if (kind == 2'h0 && nc) op_q.push_back({3'h5, 16'h0101});
        if (kind == 2'h0 && nc) ck_q.push_back(1'b0);
        op_q.push_back({3'h5, 16'h0201});
        key_q.push_back(aes ? sec : {sec[127:64], 64'h0});
        @(posedge i_core_clk);
        #2 i_kx_kind = kind;
        i_kx_new_cookie = nc;
        i_ctx_aes = aes;
        dly = d;
        i_kx_start = 1'b1;
        @(posedge i_core_clk);
        #2 i_kx_start = 1'b0;
        settle();
    endtask

    // ======================================================
    // Main sequence
    initial begin
        seed = 32'h01DE;
        {fails, checks} = '0;
        {i_ctx_ctr, i_ctx_aes, i_new_key, i_unit_start, i_ks_next, i_pad_ready} = '0;
        {i_strip_req, i_kx_start, i_kx_new_cookie, i_kx_kind, dly} = '0;
        {i_key_nonce, i_unit_len, i_rand_iv, i_enc_key, i_last_byte} = '0;
        i_reset_n = 1'b0;
        repeat (2) @(posedge i_core_clk);
        #2 i_reset_n = 1'b1;
        new_key(32'hA5C3_0F19);
        unit(1'b1, 1'b1, 36'h0_0000_0040, 3, 3'b000);
        cmp("ctr block", {nonce, master - 64'h1, 32'h1}, 160'(o_ctr_block));
        @(posedge i_core_clk);
        #2 i_ks_next = 1'b1;
        @(posedge i_core_clk);
        #2 i_ks_next = 1'b0;
        cmp("ctr block", {nonce, master - 64'h1, 32'h2}, 160'(o_ctr_block));
        unit(1'b1, 1'b1, 36'hF_FFFF_FFF0, 1, 3'b000);
        unit(1'b1, 1'b1, 36'hF_FFFF_FFF1, 1, 3'b001);
        new_key(32'h3C96_E17B);
        unit(1'b1, 1'b1, 36'h0_0000_0001, 1, 3'b000);
        cmp("ctr block", {nonce, master - 64'h1, 32'h1}, 160'(o_ctr_block));
        unit(1'b0, 1'b1, 36'h0_0000_0020, 2, 3'b010);
        unit(1'b0, 1'b1, 36'h0_0000_0023, 1, 3'b000);
        unit(1'b0, 1'b0, 36'h0_0000_0010, 1, 3'b000);
        unit(1'b0, 1'b0, 36'h0_0000_000D, 1, 3'b000);
        strip(1'b1, 8'h01, 1'b0);
        strip(1'b1, 8'h10, 1'b0);
        strip(1'b1, 8'h00, 1'b1);
        strip(1'b1, 8'h11, 1'b1);
        strip(1'b0, 8'h08, 1'b0);
        strip(1'b0, 8'h09, 1'b1);
        kx(2'h0, 1'b1, 1'b1, 4'h0);
        kx(2'h1, 1'b0, 1'b0, 4'h9);
        kx(2'h2, 1'b0, 1'b1, 4'h3);
        kx(2'h0, 1'b0, 1'b1, 4'h1);
        cmp("leftover", 160'h0, 160'(ck_q.size()));
        give_verdict();
    end
endmodule // payload_cipher_keying_test
